/* File: rtl/agia_map.svh */
// register offsets, field positions and reset values of the gain access block
`ifndef AGIA_MAP_SVH
`define AGIA_MAP_SVH
`define AGIA_CFG_GAIN_EN_BIT 0
`define AGIA_IDX_GAIN_UPPER  8'h04
`define AGIA_IDX_GAIN_LOWER  8'h07
`define AGIA_IDX_GAIN_ADD    8'h08
`define AGIA_LOWER_NIB_MSB   7
`define AGIA_LOWER_NIB_LSB   4
`define AGIA_ADD_BIT         0
`define AGIA_RST_BYTE        8'h00
`define AGIA_RST_GAIN        12'h000
`define AGIA_RST_ENABLE      1'b0
`define AGIA_RST_ADD         1'b0
`endif

/* File: rtl/agia_pkg.sv */
// types shared by the gain access block
package agia_pkg;
    typedef struct packed {
        logic       cfg_wr;
        logic       high_wr;
        logic       low_wr;
        logic [7:0] wdata;
    } agia_wr_t;

    typedef struct packed {
        logic [11:0] gain;
        logic        gain_add;
    } agia_gain_t;
endpackage

/* File: rtl/agia_gain_access.sv */
// indirect write-only access path to the converter gain registers
`timescale 1ns/10ps
`default_nettype none
`include "agia_map.svh"

// Summary of operation
// - with access enable set, high writes select address, low writes load data.
// - three gain registers exist, reachable only through the indirect path.
// - gain registers are write-only; nothing reads them back over the bus.
// - address 0x04 upper byte, 0x07 lower nibble, 0x08 gain-add control.
// - gain is 12 bits: eight from upper byte, four from lower nibble.
module agia_gain_access
    import agia_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        CFG_WR,
    input  wire logic        RESULT_HIGH_WR,
    input  wire logic        RESULT_LOW_WR,
    input  wire logic [7:0]  WDATA,
    output var  logic        GAIN_ACCESS_ENABLE,
    output var  logic [7:0]  GAIN_ADDR,
    output var  logic [11:0] GAIN_VALUE,
    output var  logic        GAIN_ADD
);

    // ------------------------------------------------------------
    // slot numbering of the indirect gain registers
    // ------------------------------------------------------------
    // one byte slot per gain register; the slots differ only in their index
    localparam int N_SLOT     = 3;
    localparam int SLOT_UPPER = 0;
    localparam int SLOT_LOWER = 1;
    localparam int SLOT_ADD   = 2;

    // ------------------------------------------------------------
    // bus request grouping
    // ------------------------------------------------------------
    agia_wr_t          wr;

    assign wr = '{cfg_wr: CFG_WR, high_wr: RESULT_HIGH_WR, low_wr: RESULT_LOW_WR, wdata: WDATA};

    // ------------------------------------------------------------
    // state, next values and decode
    // ------------------------------------------------------------
    // access enable
    logic              gain_access_enable;
    logic              next_gain_access_enable;

    // indirect index
    logic              index_wr;
    logic              data_wr;
    logic [7:0]        addr;
    logic [7:0]        next_addr;

    // gain slots
    logic [N_SLOT-1:0] slot_hit;
    logic [7:0]        gain_slot      [N_SLOT];
    logic [7:0]        next_gain_slot [N_SLOT];

    // fields seen by the analog gain path
    logic [7:0]        next_upper_field;
    logic [3:0]        next_lower_field;
    logic              next_add_field;
    agia_gain_t        gain_out;

    // registered outputs
    logic              next_out_enable;
    logic [7:0]        next_out_addr;
    logic [11:0]       next_out_gain;
    logic              next_out_add;

    // ------------------------------------------------------------
    // access enable
    // ------------------------------------------------------------
    // only bit 0 of the configuration byte belongs to this block
    always_comb begin
        next_gain_access_enable = gain_access_enable;
        if (wr.cfg_wr) begin
            next_gain_access_enable = wr.wdata[`AGIA_CFG_GAIN_EN_BIT];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            gain_access_enable <= `AGIA_RST_ENABLE;
        end else begin
            gain_access_enable <= next_gain_access_enable;
        end
    end

    // ------------------------------------------------------------
    // result writes qualified by the access enable
    // ------------------------------------------------------------
    // the enable as it stood before this edge counts, so opening access
    // in the same cycle as a result write does not steer that write;
    // the software order is not enforced, an early index is simply dropped
    always_comb begin
        index_wr = gain_access_enable & wr.high_wr;
        data_wr  = gain_access_enable & wr.low_wr;
    end

    // ------------------------------------------------------------
    // indirect index register
    // ------------------------------------------------------------
    // the index stays after access closes; a new session should rewrite it
    always_comb begin
        next_addr = addr;
        if (index_wr) begin
            next_addr = wr.wdata;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            addr <= `AGIA_RST_BYTE;
        end else begin
            addr <= next_addr;
        end
    end

    // ------------------------------------------------------------
    // index decode
    // ------------------------------------------------------------
    // an index outside the three slots makes a low write a no-op
    always_comb begin
        slot_hit = '0;
        if (data_wr) begin
            case (addr)
                `AGIA_IDX_GAIN_UPPER: begin
                    slot_hit[SLOT_UPPER] = 1'b1;
                end
                `AGIA_IDX_GAIN_LOWER: begin
                    slot_hit[SLOT_LOWER] = 1'b1;
                end
                `AGIA_IDX_GAIN_ADD: begin
                    slot_hit[SLOT_ADD] = 1'b1;
                end
                default: begin
                    slot_hit = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // gain register slots
    // ------------------------------------------------------------
    // write-only: nothing leads from a slot back onto the bus
    // reset clears every slot so the analog path starts at a known gain
    for (genvar i = 0; i < N_SLOT; i++) begin : g_slot
        always_comb begin
            next_gain_slot[i] = gain_slot[i];
            if (slot_hit[i]) begin
                next_gain_slot[i] = wr.wdata;
            end
        end

        always_ff @(posedge SYS_CLK) begin
            if (SYS_RST) begin
                gain_slot[i] <= `AGIA_RST_BYTE;
            end else begin
                gain_slot[i] <= next_gain_slot[i];
            end
        end
    end

    // ------------------------------------------------------------
    // gain fields
    // ------------------------------------------------------------
    // taken from the next values so the ports change at the writing edge
    always_comb begin
        next_upper_field = next_gain_slot[SLOT_UPPER];
        next_lower_field = next_gain_slot[SLOT_LOWER][`AGIA_LOWER_NIB_MSB:`AGIA_LOWER_NIB_LSB];
        next_add_field   = next_gain_slot[SLOT_ADD][`AGIA_ADD_BIT];
    end

    // ------------------------------------------------------------
    // gain value assembly
    // ------------------------------------------------------------
    always_comb begin
        gain_out.gain     = {next_upper_field, next_lower_field};
        gain_out.gain_add = next_add_field;
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // enable and index are echoed for the converter's own sequencing
    always_comb begin
        next_out_enable = next_gain_access_enable;
        next_out_addr   = next_addr;
        next_out_gain   = gain_out.gain;
        next_out_add    = gain_out.gain_add;
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            GAIN_ACCESS_ENABLE <= `AGIA_RST_ENABLE;
            GAIN_ADDR          <= `AGIA_RST_BYTE;
            GAIN_VALUE         <= `AGIA_RST_GAIN;
            GAIN_ADD           <= `AGIA_RST_ADD;
        end else begin
            GAIN_ACCESS_ENABLE <= next_out_enable;
            GAIN_ADDR          <= next_out_addr;
            GAIN_VALUE         <= next_out_gain;
            GAIN_ADD           <= next_out_add;
        end
    end

endmodule
`default_nettype wire

/* File: tb/agia_gain_access_assertions.sv */
// gain access checker
`timescale 1ns/10ps
`default_nettype none
module agia_checker (
    input wire logic        SYS_CLK,
    input wire logic        SYS_RST,
    input wire logic        CFG_WR,
    input wire logic        RESULT_HIGH_WR,
    input wire logic        RESULT_LOW_WR,
    input wire logic [7:0]  WDATA,
    input wire logic        GAIN_ACCESS_ENABLE,
    input wire logic [7:0]  GAIN_ADDR,
    input wire logic [11:0] GAIN_VALUE,
    input wire logic        GAIN_ADD
);
    wire logic odd = !(GAIN_ADDR inside {8'h04, 8'h07, 8'h08});
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    sequence s_ld(a); GAIN_ACCESS_ENABLE && RESULT_LOW_WR && GAIN_ADDR == a; endsequence
    sequence s_keep; $stable(GAIN_VALUE) && $stable(GAIN_ADD); endsequence
    a_enable_bit: assert property (CFG_WR |=> GAIN_ACCESS_ENABLE == $past(WDATA[0])) else $error("en");
    a_addr_pick: assert property (GAIN_ACCESS_ENABLE && RESULT_HIGH_WR |=> GAIN_ADDR == $past(WDATA)) else $error("ad");
    a_upper_load: assert property (s_ld(8'h04) |=> GAIN_VALUE[11:4] == $past(WDATA)) else $error("hi");
    a_lower_load: assert property (s_ld(8'h07) |=> GAIN_VALUE[3:0] == $past(WDATA[7:4])) else $error("lo");
    a_add_bit: assert property (s_ld(8'h08) |=> GAIN_ADD == $past(WDATA[0])) else $error("add");
    a_bad_index: assert property (GAIN_ACCESS_ENABLE && RESULT_LOW_WR && odd |=> s_keep) else $error("idx");
    a_gain_locked: assert property (!GAIN_ACCESS_ENABLE |=> s_keep) else $error("lock");
    a_addr_locked: assert property (!GAIN_ACCESS_ENABLE |=> $stable(GAIN_ADDR)) else $error("addr lock");
endmodule
bind agia_gain_access agia_checker chk_u (
    .SYS_CLK            (SYS_CLK),
    .SYS_RST            (SYS_RST),
    .CFG_WR             (CFG_WR),
    .RESULT_HIGH_WR     (RESULT_HIGH_WR),
    .RESULT_LOW_WR      (RESULT_LOW_WR),
    .WDATA              (WDATA),
    .GAIN_ACCESS_ENABLE (GAIN_ACCESS_ENABLE),
    .GAIN_ADDR          (GAIN_ADDR),
    .GAIN_VALUE         (GAIN_VALUE),
    .GAIN_ADD           (GAIN_ADD)
);
`default_nettype wire

/* File: tb/testbench.sv */
// gain access bench
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("Error %s exp %h got %h", n, e, g); end end
module testbench;
    import agia_pkg::*;
    logic        clk = 0, rst = 1, en = 0, ga = 0, ok = 0, q_en, q_ga;
    logic [7:0]  lf = 8'h33, ad = 0, gh = 0, gl = 0, q_ad;
    logic [11:0] q_gv;
    logic [10:0] walk [10] = '{11'h401, 11'h204, 11'h16c, 11'h207, 11'h1a0, 11'h208, 11'h101, 11'h304, 11'h400, 11'h155};
    agia_wr_t    w = '0, rw;
    int          n_mismatch = 0, checks_done = 0;
    always #25 clk = ~clk;
    agia_gain_access dut_u (.SYS_CLK(clk), .SYS_RST(rst), .CFG_WR(w.cfg_wr), .RESULT_HIGH_WR(w.high_wr),
        .RESULT_LOW_WR(w.low_wr), .WDATA(w.wdata), .GAIN_ACCESS_ENABLE(q_en), .GAIN_ADDR(q_ad),
        .GAIN_VALUE(q_gv), .GAIN_ADD(q_ga));
    function automatic logic [7:0] nx(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // gain as the analog path sees it: upper byte, then the lower register's top nibble
    function automatic logic [11:0] exp_gain(logic [7:0] up, logic [7:0] lo);
        return {up, lo[7:4]};
    endfunction
    // low write acts on the address held before the edge
    task automatic step(agia_wr_t x);
        w = x;
        @(negedge clk);
        if (en && x.low_wr && ad == 8'h04) gh = x.wdata;
        if (en && x.low_wr && ad == 8'h07) gl = x.wdata;
        if (en && x.low_wr && ad == 8'h08) ga = x.wdata[0];
        if (en && x.high_wr) {ok, ad} = {1'b1, x.wdata};
        if (x.cfg_wr) {ok, en} = {1'b0, x.wdata[0]};
        `CHK("en", en, q_en)
        `CHK("addr", ad, q_ad)
        `CHK("gain", exp_gain(gh, gl), q_gv)
        `CHK("add", ga, q_ga)
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst = 0;
        foreach (walk[i]) step(agia_wr_t'(walk[i]));
        // with access open, low writes held back until an address is chosen after enabling
        repeat (400) begin
            lf = nx(lf);
            rw = {lf[2:0] == 3'h0, lf[4], lf[5] & (ok | !en), 8'h00};
            lf = nx(lf);
            rw.wdata = lf[7] ? lf : (lf[6] ? 8'h04 : (lf[5] ? 8'h07 : 8'h08));
            step(rw);
        end
        // reset in mid-run with gain state loaded, then the walk once more
        rst = 1;
        repeat (2) @(negedge clk);
        `CHK("rst en", 1'b0, q_en)
        `CHK("rst addr", 8'h00, q_ad)
        `CHK("rst gain", 12'h000, q_gv)
        `CHK("rst add", 1'b0, q_ga)
        {en, ad, gh, gl, ga, ok} = '0;
        rst = 0;
        foreach (walk[i]) step(agia_wr_t'(walk[i]));
        report_and_stop();
    end
endmodule
`default_nettype wire
